// >>> logic/updpw_pkg.sv
// Package for the up/down PWM output unit: register map, fields, codes.
// Assumes a 32-bit plain register port with byte addresses.
package updpw_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_COUNT  = 8'h08;
	localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
	localparam logic [7:0] ADDR_VECTOR = 8'h10;
	localparam logic [7:0] ADDR_CHMODE = 8'h14;
	localparam logic [7:0] ADDR_CMP1   = 8'h20;
	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DIV_LSB  = 2;
	localparam int CTRL_CLR_BIT  = 4;
	// Flag positions
	localparam int FLAG_PERIOD = 0;
	localparam int FLAG_CH1    = 1;
	localparam int FLAG_OVF    = 5;
	localparam int NUM_CH      = 4;
	localparam int FLAG_W      = 6;
	// Vector code step and reset values
	localparam logic [3:0] VEC_STEP    = 4'h2;
	localparam logic [15:0] PERIOD_RST = 16'hfffe;
	localparam logic [15:0] CMP_RST    = 16'h0000;
	// Counting modes
	typedef enum logic [1:0] {
		CNT_STOP   = 2'h0,
		CNT_UP     = 2'h1,
		CNT_UPDOWN = 2'h2,
		CNT_RSVD   = 2'h3
	} updpw_cnt_t;
	// Output modes
	typedef enum logic [2:0] {
		OM_BIT = 3'h0, OM_SET = 3'h1, OM_TGLRST = 3'h2, OM_SETRST = 3'h3,
		OM_TGL = 3'h4, OM_RST = 3'h5, OM_TGLSET = 3'h6, OM_RSTSET = 3'h7
	} updpw_om_t;
	// Per-channel configuration carried together
	typedef struct packed {
		logic      outVal;
		updpw_om_t mode;
	} updpw_chcfg_t;
	// Counting direction, one-hot
	typedef enum logic [1:0] {
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} updpw_dir_t;
endpackage

// >>> logic/updpw_unit.sv
// Up/down PWM output unit: prescaler, counter, period and channel compares,
// output units, match flags and an interrupt vector register.
// Assumes a master on the same clock that never waits; read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module updpw_unit
	import updpw_pkg::*;
#(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Register port
	input  wire logic [7:0]        addr,
	input  wire logic [31:0]       wrData,
	input  wire logic              wrStb,
	input  wire logic              rdStb,
	output logic      [31:0]       rdData,
	// Channel output pins
	output logic      [NUM_CH-1:0] channel_output_pin
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	updpw_cnt_t                cntMode, next_cntMode;
	logic [1:0]                divSel, next_divSel;
	logic [CW-1:0]             period_compare_register, next_period;
	logic [CW-1:0]             channel_compare_register [NUM_CH];
	logic [CW-1:0]             next_cmp [NUM_CH];
	updpw_chcfg_t [NUM_CH-1:0] chCfg, next_chCfg;
	logic [FLAG_W-1:0]         flags, next_flags;
	logic [31:0]               next_rdData;
	logic                      clrReq;
	// Timer state
	logic [2:0]                preCnt, next_preCnt;
	logic [CW-1:0]             count, next_count;
	updpw_dir_t                dir, next_dir;
	logic [NUM_CH-1:0]         next_out;
	// Events of this cycle
	logic                      tick;
	logic                      period_match_flag;
	logic                      counter_overflow_flag;
	logic [NUM_CH-1:0]         channel_equal_signal;
	logic [FLAG_W-1:0]         evSet;
	logic [3:0]                vecCode;
	logic [FLAG_W-1:0]         vecClr;

	// Highest pending vector source: channels first, overflow last
	function automatic logic [3:0] vec_of(input logic [FLAG_W-1:0] f);
		logic [3:0] v;
		v = 4'h0;
		for (int i = FLAG_OVF; i >= FLAG_CH1; i--) begin
			if (f[i]) begin
				v = VEC_STEP * 4'(i);
			end
		end
		return v;
	endfunction

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------
	// Tick once every 1, 2, 4 or 8 input clocks
	assign tick = (cntMode inside {CNT_UP, CNT_UPDOWN}) &&
	              (preCnt == 3'((4'h1 << divSel) - 4'h1));
	// Period match as the counter reaches the period value
	assign period_match_flag = tick && (count == period_compare_register);
	// Overflow at wrap in up mode, at the bottom turn in up/down
	assign counter_overflow_flag = tick && ((cntMode == CNT_UP) ?
	       (count >= period_compare_register) : (dir == DIR_DOWN && count == '0));
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			channel_equal_signal[i] = tick && (count == channel_compare_register[i]);
		end
	end

	// Counter next state; clear restarts everything at zero going up
	always_comb begin
		next_preCnt = tick ? 3'h0 : preCnt + 3'h1;
		next_count  = count;
		next_dir    = dir;
		if (cntMode == CNT_STOP || cntMode == CNT_RSVD) begin
			next_preCnt = 3'h0;
		end
		if (tick && cntMode == CNT_UP) begin
			// Up: period value plus one timer clocks
			next_count = (count >= period_compare_register) ? '0 : count + 1'b1;
			next_dir   = DIR_UP;
		end else if (tick) begin
			// Up to period, down to zero, two times period long
			if (period_compare_register == '0) begin
				next_count = '0;
			end else if (dir == DIR_UP && count >= period_compare_register) begin
				next_dir   = DIR_DOWN;
				next_count = count - 1'b1;
			end else if (dir == DIR_DOWN && count == '0) begin
				next_dir   = DIR_UP;
				next_count = count + 1'b1;
			end else begin
				next_count = (dir == DIR_UP) ? count + 1'b1 : count - 1'b1;
			end
		end
		if (clrReq) begin
			next_preCnt = 3'h0;
			next_count  = '0;
			next_dir    = DIR_UP;
		end
	end

	// ----------------------------------------
	// Output units
	// ----------------------------------------
	// Compare above period never matches, so outputs then change only at period match
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_out[i] = channel_output_pin[i];
			unique case (chCfg[i].mode)
				OM_BIT:    next_out[i] = chCfg[i].outVal;
				OM_SET:    next_out[i] = 1'b1;
				OM_RST:    next_out[i] = 1'b0;
				// Toggle at match, reset at period
				OM_TGLRST: begin
					if (period_match_flag) next_out[i] = 1'b0;
					else if (channel_equal_signal[i]) next_out[i] = ~channel_output_pin[i];
				end
				// Toggle at match, set at period
				OM_TGLSET: begin
					if (period_match_flag) next_out[i] = 1'b1;
					else if (channel_equal_signal[i]) next_out[i] = ~channel_output_pin[i];
				end
				// Kept for up mode; software avoids these in up/down
				OM_SETRST: begin
					if (period_match_flag) next_out[i] = 1'b0;
					else if (channel_equal_signal[i]) next_out[i] = 1'b1;
				end
				OM_RSTSET: begin
					if (period_match_flag) next_out[i] = 1'b1;
					else if (channel_equal_signal[i]) next_out[i] = 1'b0;
				end
				OM_TGL: begin
					if (channel_equal_signal[i]) next_out[i] = ~channel_output_pin[i];
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			preCnt             <= 3'h0;
			count              <= '0;
			dir                <= DIR_UP;
			channel_output_pin <= '0;
		end else begin
			preCnt             <= next_preCnt;
			count              <= next_count;
			dir                <= next_dir;
			channel_output_pin <= next_out;
		end
	end

	// ----------------------------------------
	// Registers, flags and vector
	// ----------------------------------------
	// Each compare match sets its flag; up/down meets it twice a period, once at zero or the period value
	assign evSet = {counter_overflow_flag, channel_equal_signal, period_match_flag};
	// Reading the vector returns and clears the top source
	assign vecCode = vec_of(flags);
	assign clrReq  = wrStb && addr == ADDR_CTRL && wrData[CTRL_CLR_BIT];
	always_comb begin
		vecClr = '0;
		if (rdStb && addr == ADDR_VECTOR && vecCode != 4'h0) begin
			vecClr[vecCode[3:1]] = 1'b1;
		end
	end

	always_comb begin
		next_cntMode = cntMode;
		next_divSel  = divSel;
		next_period  = period_compare_register;
		next_chCfg   = chCfg;
		for (int i = 0; i < NUM_CH; i++) begin
			next_cmp[i] = channel_compare_register[i];
		end
		next_flags = flags & ~vecClr;
		if (wrStb) begin
			if (addr == ADDR_CTRL) begin
				next_cntMode = updpw_cnt_t'(wrData[CTRL_MODE_LSB +: 2]);
				next_divSel  = wrData[CTRL_DIV_LSB +: 2];
			end
			if (addr == ADDR_PERIOD) next_period = wrData[CW-1:0];
			if (addr == ADDR_CHMODE) next_chCfg = wrData[4*NUM_CH-1:0];
			if (addr == ADDR_FLAGS) next_flags = next_flags & ~wrData[FLAG_W-1:0];
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr == ADDR_CMP1 + 8'(4 * i)) next_cmp[i] = wrData[CW-1:0];
			end
		end
		// Set wins over any clear in the same cycle
		next_flags = next_flags | evSet;
		next_rdData = 32'h0;
		if (rdStb) begin
			unique case (addr)
				ADDR_CTRL:   next_rdData = {27'h0, 1'b0, divSel, cntMode};
				ADDR_PERIOD: next_rdData = 32'(period_compare_register);
				ADDR_COUNT:  next_rdData = 32'(count);
				ADDR_FLAGS:  next_rdData = 32'(flags);
				ADDR_VECTOR: next_rdData = 32'(vecCode);
				ADDR_CHMODE: next_rdData = 32'(chCfg);
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (addr == ADDR_CMP1 + 8'(4 * i)) begin
							next_rdData = 32'(channel_compare_register[i]);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cntMode                 <= CNT_STOP;
			divSel                  <= 2'h0;
			period_compare_register <= CW'(PERIOD_RST);
			chCfg                   <= '0;
			flags                   <= '0;
			rdData                  <= 32'h0;
			for (int i = 0; i < NUM_CH; i++) channel_compare_register[i] <= CW'(CMP_RST);
		end else begin
			cntMode                 <= next_cntMode;
			divSel                  <= next_divSel;
			period_compare_register <= next_period;
			chCfg                   <= next_chCfg;
			flags                   <= next_flags;
			rdData                  <= next_rdData;
			for (int i = 0; i < NUM_CH; i++) channel_compare_register[i] <= next_cmp[i];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_period_flag_set: assert property (period_match_flag |=> flags[FLAG_PERIOD])
		else $error("period match flag not set");
	a_up_wrap_zero: assert property (tick && cntMode == CNT_UP && !clrReq &&
		count >= period_compare_register |=> count == '0)
		else $error("up count did not wrap");
	a_updown_turn: assert property (tick && cntMode == CNT_UPDOWN && !clrReq &&
		dir == DIR_DOWN && count == '0 && period_compare_register != '0
		|=> dir == DIR_UP && count == 1)
		else $error("up/down turn missing");
	// Only judged while divider and mode stay put for the whole window
	a_div_spacing: assert property (tick && divSel == 2'h3 && !clrReq ##1
		(divSel == 2'h3 && !clrReq && cntMode inside {CNT_UP, CNT_UPDOWN}) [*8] |-> tick)
		else $error("divider spacing wrong");
	a_set_mode_high: assert property (chCfg[0].mode == OM_SET |=> channel_output_pin[0])
		else $error("set mode not high");
	a_rst_mode_low: assert property (chCfg[0].mode == OM_RST |=> !channel_output_pin[0])
		else $error("reset mode not low");
	a_tglrst_reset: assert property (chCfg[0].mode == OM_TGLRST && period_match_flag
		|=> !channel_output_pin[0])
		else $error("toggle/reset not low at period");
	a_big_cmp_hold: assert property (chCfg[3].mode == OM_TGLSET &&
		channel_compare_register[3] > period_compare_register
		|=> channel_output_pin[3] == ($past(period_match_flag) || $past(channel_output_pin[3])))
		else $error("output moved with compare above period");
	a_vec_code: assert property (rdStb && addr == ADDR_VECTOR && flags[FLAG_CH1]
		|=> rdData == 32'h2)
		else $error("vector code for channel one wrong");
	a_vec_idle: assert property (rdStb && addr == ADDR_VECTOR && flags[FLAG_OVF:FLAG_CH1] == '0
		|=> rdData == 32'h0)
		else $error("vector not zero when idle");

	c_updown_turn: cover property (tick && cntMode == CNT_UPDOWN && dir == DIR_DOWN);
	c_zero_cmp: cover property (channel_equal_signal[0] && channel_compare_register[0] == '0);
	c_ovf_vector: cover property (rdStb && addr == ADDR_VECTOR && vecCode == 4'ha);
endmodule
`default_nettype wire

// >>> sim/test_updown_pwm_output_unit.sv
// Testbench for the up/down PWM output unit: register tasks and sequences.
// Assumes the unit and the pin monitor; the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module test_updown_pwm_output_unit import updpw_pkg::*;;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic [7:0]        addr = 8'h00;
	logic [31:0]       wrData = 32'h0;
	logic              wrStb = 1'b0;
	logic              rdStb = 1'b0;
	logic [31:0]       rdData;
	logic [NUM_CH-1:0] pins;
	logic [15:0]       hiLen [NUM_CH];
	logic [15:0]       perLen [NUM_CH];
	int                error_cnt = 0;
	int                num_checks = 0;
	int                cycles = 0;
	int                nCh;
	int                nOvf;

	updpw_unit #(.CW(16)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .channel_output_pin(pins));
	updpw_load u_load (.clk(clk), .pins(pins), .hiLen(hiLen), .perLen(perLen));

	// 250 MHz clock
	always #2 clk = ~clk;

	// Hang guard: well above the few thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		v = rdData;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] v;
		rd(a, v);
		chk(nm, v, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic steady(input int i, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			tick(1);
			if (pins[i] !== v)
				bad = 1'b1;
		end
		chk("steady pin", {31'h0, bad}, 32'h0);
	endtask
	// Channel 1 codes between the first and fifth overflow: four periods
	task automatic countPeriods();
		logic [31:0] v;
		nCh = 0;
		nOvf = 0;
		wr(ADDR_FLAGS, 32'h3f);
		for (int k = 0; k < 600 && nOvf < 5; k++) begin
			rd(ADDR_VECTOR, v);
			if (v === 32'ha)
				nOvf++;
			else if (v === 32'h2 && nOvf > 0)
				nCh++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rdc(ADDR_PERIOD, {16'h0, PERIOD_RST}, "period");
		rdc(ADDR_VECTOR, 32'h0, "vector idle");
		rdc(ADDR_FLAGS, 32'h0, "flags");
		rdc(8'h40, 32'h0, "unmapped");
		$display("test reset done");
		wr(ADDR_CHMODE, 32'h1111);
		tick(2);
		chk("set pins", {28'h0, pins}, 32'hf);
		// Direct output bits: channels 1 and 3 high, the others low
		wr(ADDR_CHMODE, 32'h0808);
		tick(2);
		chk("bit pins", {28'h0, pins}, 32'h5);
		wr(ADDR_CHMODE, 32'h5555);
		tick(2);
		chk("reset pins", {28'h0, pins}, 32'h0);
		$display("test force done");
		// Up/down PWM at every divider; the fourth compare sits above the period
		wr(ADDR_PERIOD, 32'ha);
		wr(ADDR_CMP1, 32'h3);
		wr(ADDR_CMP1 + 8'h4, 32'h0);
		wr(ADDR_CMP1 + 8'h8, 32'h4);
		wr(ADDR_CMP1 + 8'hc, 32'hff);
		wr(ADDR_CHMODE, 32'h2622);
		rdc(ADDR_CHMODE, 32'h2622, "chmode");
		rdc(ADDR_CMP1 + 8'hc, 32'hff, "cmp4");
		// Pulse widths: 2*3 high, zero compare half period, 20-2*4 high
		for (int dv = 0; dv < 4; dv++) begin
			wr(ADDR_CTRL, 32'h12 | (32'(dv) << 2));
			rdc(ADDR_CTRL, 32'h2 | (32'(dv) << 2), "ctrl");
			tick(60 << dv);
			chk("ud period", {16'h0, perLen[0]}, 32'd20 << dv);
			chk("tr high", {16'h0, hiLen[0]}, 32'd6 << dv);
			chk("zero high", {16'h0, hiLen[1]}, 32'd10 << dv);
			chk("ts high", {16'h0, hiLen[2]}, 32'd12 << dv);
			steady(3, 1'b0, 40 << dv);
		end
		// Back to a short period so the set at the period comes soon
		wr(ADDR_CTRL, 32'h12);
		wr(ADDR_CHMODE, 32'h6622);
		tick(25);
		steady(3, 1'b1, 40);
		$display("test updown done");
		// Disturb channel 1 and move its compare
		wr(ADDR_CTRL, 32'h12);
		wr(ADDR_CHMODE, 32'h6621);
		tick(7);
		wr(ADDR_CMP1, 32'h5);
		wr(ADDR_CHMODE, 32'h6622);
		tick(60);
		chk("resync high", {16'h0, hiLen[0]}, 32'd10);
		// Up mode also exercises set/reset, reset/set and toggle
		wr(ADDR_CTRL, 32'h11);
		wr(ADDR_CMP1 + 8'hc, 32'h4);
		wr(ADDR_CHMODE, 32'h4732);
		tick(60);
		chk("up period", {16'h0, perLen[0]}, 32'd11);
		chk("up high", {16'h0, hiLen[0]}, 32'd5);
		chk("setrst high", {16'h0, hiLen[1]}, 32'd10);
		chk("rstset high", {16'h0, hiLen[2]}, 32'd5);
		chk("toggle period", {16'h0, perLen[3]}, 32'd22);
		$display("test resync done");
		// Request counts with only channel 1 and overflow active
		for (int c = 1; c < 4; c++)
			wr(ADDR_CMP1 + 8'(4 * c), 32'hff);
		countPeriods();
		chk("up requests", nCh, 4);
		wr(ADDR_CHMODE, 32'h6622);
		wr(ADDR_CTRL, 32'h12);
		countPeriods();
		chk("ud requests", nCh, 8);
		$display("test counts done");
		// All sources pending, then drained through the vector
		for (int c = 0; c < 4; c++)
			wr(ADDR_CMP1 + 8'(4 * c), 32'(c + 1));
		wr(ADDR_CTRL, 32'h11);
		tick(30);
		wr(ADDR_CTRL, 32'h10);
		rdc(ADDR_COUNT, 32'h0, "count cleared");
		rdc(ADDR_FLAGS, 32'h3f, "all flags");
		for (int k = 0; k < 6; k++)
			rdc(ADDR_VECTOR, (k < 5) ? 32'(2 * (k + 1)) : 32'h0, "vector");
		rdc(ADDR_FLAGS, 32'h1, "period flag");
		wr(ADDR_FLAGS, 32'h1);
		rdc(ADDR_FLAGS, 32'h0, "cleared");
		$display("test vector done");
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> sim/updpw_load.sv
// Pin monitor standing in for the load circuit on the PWM pins.
// Assumes the pins are registered on clk; widths are counted in clk cycles.
`timescale 1ns/1ps
`default_nettype none
module updpw_load
	import updpw_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Observed pins
	input  wire logic [NUM_CH-1:0] pins,
	// Last high time and rise-to-rise period per pin
	output logic      [15:0]       hiLen [NUM_CH],
	output logic      [15:0]       perLen [NUM_CH]
);
	logic [NUM_CH-1:0] prev;
	logic [15:0]       run [NUM_CH];

	// Edge timing; a pin that never moves keeps its old figures, so
	// a steady level must be judged by sampling the pin itself
	always_ff @(posedge clk) begin
		prev <= pins;
		for (int i = 0; i < NUM_CH; i++) begin
			if (pins[i] && !prev[i]) begin
				perLen[i] <= run[i];
				run[i] <= 16'h1;
			end else begin
				run[i] <= run[i] + 16'h1;
			end
			if (!pins[i] && prev[i]) begin
				hiLen[i] <= run[i];
			end
		end
	end
endmodule
`default_nettype wire
